//--- rtl/dsf_pkg.sv
// types for the drive supervisory block
package dsf_pkg;
    typedef enum logic [1:0] {
        DSF_FS_OFF, DSF_FS_ONLY, DSF_FS_RT, DSF_RT_ONLY
    } dsf_fsrt_e;
    typedef struct packed {
        logic        pid_active;
        logic        pid_auto;
        logic [15:0] pid_error;
    } dsf_pid_s;
    typedef struct packed {
        logic        pulse_enable;
        logic        ramp_force_zero;
        logic        flying_apply;
        logic        vramp_start;
        logic        dc_brake;
    } dsf_drive_s;
endpackage

//--- rtl/dsf_regs.svh
// register offsets, reset values, limits, state codes and timing counts
`ifndef DSF_REGS_SVH
`define DSF_REGS_SVH
`define DSF_CLK_HZ          250000000
`define DSF_TICK_CYC        32'd250000
`define DSF_OFS_CTRL        8'h00
`define DSF_OFS_CURR        8'h04
`define DSF_OFS_SLEEP       8'h08
`define DSF_OFS_PID         8'h0C
`define DSF_OFS_TIMES       8'h10
`define DSF_OFS_BRAKE       8'h14
`define DSF_OFS_STATUS      8'h18
`define DSF_CTRL_RST        32'h0000_0000
`define DSF_CURR_RST        32'h0000_0000
`define DSF_SLEEP_RST       32'h0000_0000
`define DSF_PID_RST         32'h0000_0000
`define DSF_TIMES_RST       32'h0000_0014
`define DSF_BRAKE_RST       32'h0000_0000
`define DSF_RT_LIMIT_MS     2000
`define DSF_RATING_NUM      16'd3
`define DSF_STATE_SLEEP     4'h7
`define DSF_STATE_RUN       4'h1
`define DSF_STATE_READY     4'h0
`define DSF_STATE_FAULT     4'h3
`define DSF_DI_DISABLE_FS   5'd24
`define DSF_CURR_MAX        16'd2000
`define DSF_SFREQ_MAX       16'd5000
`define DSF_STIME_MAX       16'd999
`define DSF_VRISE_MIN       16'd2
`define DSF_VRISE_MAX       16'd600
`define DSF_BTIME_MAX       16'd150
`define DSF_BPCT_MAX        16'd1000
`endif

//--- rtl/dsf_supervisor.sv
// supervisory control: current limit, sleep, fs/rt, start braking
`timescale 1ns/1ns
`include "dsf_regs.svh"

module dsf_supervisor (
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         o_hrdata,
    output logic                     o_hreadyout,
    output logic                     o_hresp,
    input  wire logic                i_run_cmd,
    input  wire logic                i_undervoltage,
    input  wire logic                i_dclink_limit_active,
    input  wire logic [15:0]         i_motor_current,
    input  wire logic [15:0]         i_freq_ref,
    input  wire dsf_pkg::dsf_pid_s   i_pid,
    input  wire logic [4:0]          i_di_function,
    input  wire logic                i_di_level,
    output dsf_pkg::dsf_drive_s      o_drive,
    output logic      [15:0]         o_vrise_time,
    output logic      [15:0]         o_brake_level,
    output logic      [3:0]          o_inverter_state_code,
    output logic                     o_dc_link_undervoltage_fault
);
    import dsf_pkg::*;

    // one millisecond tick
    logic [31:0] tick_cnt;
    wire         tick_ms = (tick_cnt == `DSF_TICK_CYC - 32'd1);
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || tick_ms) begin
            tick_cnt <= 32'd0;
        end else begin
            tick_cnt <= tick_cnt + 32'd1;
        end
    end

    // pin synchronisers
    logic [3:0] sync1;
    logic [3:0] sync2;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end else begin
            sync1 <= {i_run_cmd, i_undervoltage, i_dclink_limit_active,
                      i_di_level};
            sync2 <= sync1;
        end
    end
    wire run_s   = sync2[3];
    wire uv_s    = sync2[2];
    wire dcl_s   = sync2[1];
    wire di_s    = sync2[0];

    // registers
    logic [31:0] ctrl;
    logic [31:0] curr;
    logic [31:0] sleepr;
    logic [31:0] pidr;
    logic [31:0] times;
    logic [31:0] brake;

    wire [1:0]  limiter_type_select = ctrl[1:0];
    wire [1:0]  fs_rt_select        = ctrl[3:2];
    wire [15:0] rating_selection    = ctrl[31:16];
    wire [15:0] max_output_current  = curr[15:0];
    wire [15:0] sleep_frequency     = sleepr[15:0];
    wire [15:0] sleep_time          = sleepr[31:16];
    wire [15:0] pid_wake_deviation  = pidr[15:0];
    wire [15:0] pid_sleep_deviation = pidr[31:16];
    wire [15:0] voltage_rise_time   = times[15:0];
    wire [15:0] start_braking_time  = times[31:16];
    wire [15:0] braking_voltage_level = brake[15:0];

    // ahb address phase capture
    logic       wr_pend;
    logic [7:0] wr_addr;
    wire        req     = hsel && hready && htrans[1];
    wire        do_wr   = req && hwrite;
    wire        do_rd   = req && !hwrite;

    function automatic logic [15:0] clip(input logic [15:0] v,
                                         input logic [15:0] lo,
                                         input logic [15:0] hi);
        clip = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    wire w_ctrl  = wr_pend && (wr_addr == `DSF_OFS_CTRL);
    wire w_curr  = wr_pend && (wr_addr == `DSF_OFS_CURR);
    wire w_sleep = wr_pend && (wr_addr == `DSF_OFS_SLEEP);
    wire w_pid   = wr_pend && (wr_addr == `DSF_OFS_PID);
    wire w_times = wr_pend && (wr_addr == `DSF_OFS_TIMES);
    wire w_brake = wr_pend && (wr_addr == `DSF_OFS_BRAKE);

    wire        rating_chg = w_ctrl && (hwdata[31:16] != rating_selection);
    wire [31:0] rated_lim  = 32'(hwdata[31:16]) * 32'(`DSF_RATING_NUM) / 32'd2;
    // clip the full product, not its low half
    wire [15:0] rated_clip = (rated_lim > 32'(`DSF_CURR_MAX)) ?
                             `DSF_CURR_MAX : rated_lim[15:0];
    wire [15:0] next_curr  = rating_chg ? rated_clip :
                             clip(hwdata[15:0], 16'd0, `DSF_CURR_MAX);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= do_wr;
            wr_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ctrl   <= `DSF_CTRL_RST;
            curr   <= `DSF_CURR_RST;
            sleepr <= `DSF_SLEEP_RST;
            pidr   <= `DSF_PID_RST;
            times  <= `DSF_TIMES_RST;
            brake  <= `DSF_BRAKE_RST;
        end else begin
            if (w_ctrl) begin
                ctrl <= {hwdata[31:16], 12'h000, hwdata[3:0]};
            end
            if (w_curr || rating_chg) begin
                curr <= {16'h0000, next_curr};
            end
            if (w_sleep) begin
                sleepr <= {clip(hwdata[31:16], 16'd0, `DSF_STIME_MAX),
                           clip(hwdata[15:0], 16'd0, `DSF_SFREQ_MAX)};
            end
            if (w_pid) begin
                pidr <= hwdata;
            end
            if (w_times) begin
                times <= {clip(hwdata[31:16], 16'd0, `DSF_BTIME_MAX),
                          clip(hwdata[15:0], `DSF_VRISE_MIN,
                               `DSF_VRISE_MAX)};
            end
            if (w_brake) begin
                brake <= {16'h0000,
                          clip(hwdata[15:0], 16'd0, `DSF_BPCT_MAX)};
            end
        end
    end

    // sleep logic
    logic        sleeping;
    logic [31:0] sleep_cnt;
    wire  [31:0] sleep_ms  = 32'(sleep_time) * 32'd1000;
    wire pid_ok    = !i_pid.pid_active ||
                     (i_pid.pid_error <= pid_sleep_deviation);
    wire sleep_cond = (i_freq_ref < sleep_frequency) && pid_ok && run_s;
    wire wake      = (i_freq_ref > sleep_frequency) ||
                     (i_pid.pid_auto &&
                      (i_pid.pid_error > pid_wake_deviation));
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sleeping  <= 1'b0;
            sleep_cnt <= 32'd0;
        end else if (sleeping) begin
            sleep_cnt <= 32'd0;
            if (wake || !run_s) begin
                sleeping <= 1'b0;
            end
        end else if (!sleep_cond) begin
            sleep_cnt <= 32'd0;
        end else if (sleep_cnt >= sleep_ms) begin
            sleeping <= 1'b1;
        end else if (tick_ms) begin
            sleep_cnt <= sleep_cnt + 32'd1;
        end
    end

    // flying start / ride-through
    // function select decode
    wire fs_sel = (fs_rt_select == 2'(DSF_FS_ONLY)) ||
                  (fs_rt_select == 2'(DSF_FS_RT));
    wire rt_sel = (fs_rt_select == 2'(DSF_FS_RT)) ||
                  (fs_rt_select == 2'(DSF_RT_ONLY));
    wire fs_en  = fs_sel &&
                  !(di_s && (i_di_function == `DSF_DI_DISABLE_FS));

    typedef enum logic [2:0] {
        ST_IDLE, ST_BRAKE, ST_RUN, ST_DIP, ST_FAULT
    } dsf_state_e;
    dsf_state_e  state;
    logic [31:0] tcnt;
    logic        run_q;
    logic        fly;
    logic        vstart;
    wire  [31:0] brake_ms = 32'(start_braking_time) * 32'd100;
    wire  brake_zero      = (start_braking_time == 16'h0000);
    wire  start_edge      = run_s && !run_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state  <= ST_IDLE;
            tcnt   <= 32'd0;
            run_q  <= 1'b0;
            fly    <= 1'b0;
            vstart <= 1'b0;
        end else begin
            run_q  <= run_s;
            vstart <= 1'b0;
            if (tick_ms) begin
                tcnt <= tcnt + 32'd1;
            end
            case (state)
                ST_IDLE: begin
                    tcnt <= 32'd0;
                    fly  <= 1'b0;
                    if (start_edge && brake_zero) begin
                        state  <= ST_RUN;
                        fly    <= fs_en;
                        vstart <= fs_en;
                    end else if (start_edge) begin
                        state <= ST_BRAKE;
                    end
                end
                ST_BRAKE: begin
                    if (!run_s) begin
                        state <= ST_IDLE;
                    end else if (tcnt >= brake_ms) begin
                        state  <= ST_RUN;
                        fly    <= fs_en;
                        vstart <= fs_en;
                    end
                end
                ST_RUN: begin
                    tcnt <= 32'd0;
                    if (!run_s) begin
                        state <= ST_IDLE;
                    end else if (rt_sel && uv_s) begin
                        state <= ST_DIP;
                    end else if (uv_s) begin
                        state <= ST_FAULT;
                    end
                end
                ST_DIP: begin
                    if (tcnt >= 32'(`DSF_RT_LIMIT_MS)) begin
                        state <= ST_FAULT;
                    end else if (!uv_s) begin
                        state  <= ST_RUN;
                        fly    <= 1'b1;
                        vstart <= 1'b1;
                        tcnt   <= 32'd0;
                    end
                end
                ST_FAULT: begin
                    if (!run_s) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // state decode
    wire st_idle  = (state == ST_IDLE);
    wire st_brake = (state == ST_BRAKE);
    wire st_run   = (state == ST_RUN);
    wire st_fault = (state == ST_FAULT);

    wire decel_mode = (limiter_type_select == 2'd0) ||
                      (limiter_type_select == 2'd1);
    wire force_zero = decel_mode && !dcl_s &&
                      (i_motor_current > max_output_current);

    wire [3:0] next_code = st_fault ? `DSF_STATE_FAULT :
                           sleeping ? `DSF_STATE_SLEEP :
                           st_idle  ? `DSF_STATE_READY :
                           `DSF_STATE_RUN;

    wire [31:0] status_word = {16'h0000, 7'h00, sleeping,
                               1'b0, 3'(state), next_code};
    wire [31:0] rd_mux =
        (haddr[7:0] == `DSF_OFS_CTRL)   ? ctrl   :
        (haddr[7:0] == `DSF_OFS_CURR)   ? curr   :
        (haddr[7:0] == `DSF_OFS_SLEEP)  ? sleepr :
        (haddr[7:0] == `DSF_OFS_PID)    ? pidr   :
        (haddr[7:0] == `DSF_OFS_TIMES)  ? times  :
        (haddr[7:0] == `DSF_OFS_BRAKE)  ? brake  :
        (haddr[7:0] == `DSF_OFS_STATUS) ? status_word : 32'h0000_0000;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_hrdata     <= 32'h0000_0000;
            o_hreadyout  <= 1'b1;
            o_hresp      <= 1'b0;
            o_drive      <= '0;
            o_vrise_time <= 16'h0000;
            o_brake_level <= 16'h0000;
            o_inverter_state_code <= `DSF_STATE_READY;
            o_dc_link_undervoltage_fault <= 1'b0;
        end else begin
            // read data for the data phase
            o_hrdata <= do_rd ? rd_mux : 32'h0000_0000;
            o_drive.pulse_enable <= st_run && !sleeping;
            o_drive.ramp_force_zero <= force_zero;
            o_drive.flying_apply <= fly && st_run;
            o_drive.vramp_start  <= vstart;
            o_drive.dc_brake     <= st_brake;
            o_vrise_time  <= voltage_rise_time;
            o_brake_level <= braking_voltage_level;
            o_inverter_state_code <= next_code;
            o_dc_link_undervoltage_fault <= st_fault;
        end
    end
endmodule // dsf_supervisor

//--- verification/drive_supervisory_functions_tb.sv
// self-checking bench for the supervisory block
`timescale 1ns/1ns
`include "dsf_regs.svh"
module drive_supervisory_functions_tb;
    import dsf_pkg::*;
    logic        clk, rst, hsel, hwrite, hready, hresp, run, dip, dcl_req;
    logic [31:0] haddr, hwdata, hrdata, seed, v;
    logic [1:0]  htrans;
    logic [15:0] freq_ref, load, curr, vrise, blevel;
    logic [4:0]  di_fn;
    logic        di_lvl, uv, dcl, fault;
    logic [3:0]  code;
    dsf_pid_s    pid;
    dsf_drive_s  drive;
    int          errors = 0, comparisons = 0, vr_cnt = 0, vc, br_cnt = 0;
    dsf_supervisor u_dsf_supervisor (.i_clk_sys(clk), .i_rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_run_cmd(run), .i_undervoltage(uv), .i_dclink_limit_active(dcl),
        .i_motor_current(curr), .i_freq_ref(freq_ref), .i_pid(pid),
        .i_di_function(di_fn), .i_di_level(di_lvl), .o_drive(drive),
        .o_vrise_time(vrise), .o_brake_level(blevel),
        .o_inverter_state_code(code), .o_dc_link_undervoltage_fault(fault));
    dsf_plant u_dsf_plant (.i_clk_sys(clk), .i_drive(drive), .i_load(load),
        .i_dip(dip), .i_dcl_req(dcl_req), .o_motor_current(curr),
        .o_undervoltage(uv), .o_dclink_limit_active(dcl));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] rating_max(input logic [15:0] r);
        logic [31:0] m;
        m = 32'(r) * 3 / 2;
        return (m > 32'd2000) ? 32'd2000 : m;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        chk(q, exp);
    endtask
    task automatic summarize;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (drive.vramp_start === 1'b1) vr_cnt++;
    always @(posedge clk) if (drive.dc_brake === 1'b1) br_cnt++;
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        summarize;
    end
    initial begin
        {rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
        {run, dip, dcl_req, di_lvl, di_fn, freq_ref, load} = '0;
        pid = '0;
        seed = 32'h0F1F93CB;
        cyc(5);
        rst <= 1'b0;
        rdc(`DSF_OFS_CTRL, `DSF_CTRL_RST);
        rdc(`DSF_OFS_TIMES, `DSF_TIMES_RST);
        rdc(`DSF_OFS_STATUS, 32'h00000000);
        wr(8'h1C, 32'hFFFFFFFF);
        rdc(8'h1C, 32'h00000000);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            v = seed % 32'd2001;
            wr(`DSF_OFS_CURR, v);
            rdc(`DSF_OFS_CURR, v);
        end
        wr(`DSF_OFS_CURR, 32'd3000);
        rdc(`DSF_OFS_CURR, 32'd2000);
        wr(`DSF_OFS_CTRL, {16'd100, 16'h0000});
        rdc(`DSF_OFS_CURR, rating_max(16'd100));
        wr(`DSF_OFS_CTRL, {16'd1500, 16'h0000});
        rdc(`DSF_OFS_CURR, rating_max(16'd1500));
        wr(`DSF_OFS_TIMES, 32'd1);
        cyc(2);
        chk(32'(vrise), 32'(`DSF_VRISE_MIN));
        wr(`DSF_OFS_TIMES, 32'd700);
        cyc(2);
        chk(32'(vrise), 32'(`DSF_VRISE_MAX));
        wr(`DSF_OFS_BRAKE, 32'd500);
        cyc(2);
        chk(32'(blevel), 32'd500);
        for (int lt = 0; lt < 4; lt++) begin
            run <= 1'b0;
            cyc(8);
            wr(`DSF_OFS_CTRL, {16'd1500, 14'h0000, 2'(lt)});
            wr(`DSF_OFS_CURR, 32'd100);
            run <= 1'b1;
            load <= 16'd50;
            cyc(10);
            chk(32'(drive.pulse_enable), 32'd1);
            load <= 16'd300;
            cyc(10);
            chk(32'(drive.ramp_force_zero), 32'(lt < 2));
            dcl_req <= 1'b1;
            cyc(10);
            chk(32'(drive.ramp_force_zero), 32'd0);
            {dcl_req, load} <= {1'b0, 16'd50};
            cyc(10);
            chk(32'(drive.ramp_force_zero), 32'd0);
        end
        for (int m = 0; m < 6; m++) begin
            run <= 1'b0;
            {di_lvl, di_fn} <= {m > 3, (m == 4) ? `DSF_DI_DISABLE_FS : 5'd5};
            cyc(8);
            wr(`DSF_OFS_CTRL, {16'd1500, 12'h000, 2'(m > 3 ? 1 : m), 2'd2});
            vc = vr_cnt;
            run <= 1'b1;
            cyc(10);
            chk(32'(vr_cnt - vc), 32'(m == 1 || m == 2 || m == 5));
            chk(32'(drive.flying_apply),
                32'(m == 1 || m == 2 || m == 5));
            dip <= 1'b1;
            cyc(10);
            chk(32'(fault), 32'(m < 2 || m > 3));
            chk(32'(drive.pulse_enable), 32'd0);
            dip <= 1'b0;
            cyc(10);
            chk(32'(drive.pulse_enable), 32'(m == 2 || m == 3));
            chk(32'(drive.flying_apply), 32'(m == 2 || m == 3));
            chk(32'(vr_cnt - vc), 32'(m == 2) + 32'(m != 0 && m != 4));
        end
        run <= 1'b0;
        cyc(8);
        run <= 1'b1;
        cyc(10);
        chk(32'(code), 32'(`DSF_STATE_RUN));
        wr(`DSF_OFS_SLEEP, 32'd100);
        freq_ref <= 16'd50;
        cyc(10);
        chk(32'(code), 32'(`DSF_STATE_SLEEP));
        chk(32'(drive.pulse_enable), 32'd0);
        freq_ref <= 16'd200;
        cyc(10);
        chk(32'(code), 32'(`DSF_STATE_RUN));
        wr(`DSF_OFS_SLEEP, 32'd0);
        freq_ref <= 16'd0;
        cyc(10);
        chk(32'(code), 32'(`DSF_STATE_RUN));
        wr(`DSF_OFS_PID, {16'd10, 16'd500});
        pid <= '{1'b1, 1'b0, 16'd50};
        wr(`DSF_OFS_SLEEP, 32'd100);
        freq_ref <= 16'd50;
        cyc(10);
        chk(32'(code), 32'(`DSF_STATE_RUN));
        pid <= '{1'b1, 1'b0, 16'd5};
        cyc(10);
        chk(32'(code), 32'(`DSF_STATE_SLEEP));
        pid <= '{1'b1, 1'b1, 16'd600};
        cyc(10);
        chk(32'(code), 32'(`DSF_STATE_RUN));
        chk(32'(br_cnt), 32'd0);
        summarize;
    end
endmodule // drive_supervisory_functions_tb

//--- verification/dsf_plant.sv
// far side model: power stage current, supply and dc-link monitors
`timescale 1ns/1ns
module dsf_plant (
    input  wire logic                i_clk_sys,
    input  wire dsf_pkg::dsf_drive_s i_drive,
    input  wire logic [15:0]         i_load,
    input  wire logic                i_dip,
    input  wire logic                i_dcl_req,
    output logic      [15:0]         o_motor_current = 16'h0000,
    output logic                     o_undervoltage = 1'b0,
    output logic                     o_dclink_limit_active = 1'b0
);
    import dsf_pkg::*;
    // current flows only while pulses switch
    always @(posedge i_clk_sys) begin
        o_motor_current <= i_drive.pulse_enable ? i_load : 16'h0000;
        o_undervoltage <= i_dip;
        o_dclink_limit_active <= i_dcl_req;
    end
endmodule // dsf_plant

//--- verification/dsf_supervisor_chk.sv
// assertions on the supervisory block ports, bound to the design
`timescale 1ns/1ns
`include "dsf_regs.svh"
module dsf_supervisor_chk (
    input wire logic                i_clk_sys,
    input wire logic                i_rst,
    input wire logic                i_run_cmd,
    input wire logic                i_dclink_limit_active,
    input wire logic [15:0]         i_motor_current,
    input wire logic                o_hreadyout,
    input wire logic                o_hresp,
    input wire dsf_pkg::dsf_drive_s o_drive,
    input wire logic [3:0]          o_inverter_state_code,
    input wire logic                o_dc_link_undervoltage_fault
);
    import dsf_pkg::*;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    sequence run_low_s;
        (!i_run_cmd) [*6];
    endsequence
    sequence dcl_on_s;
        i_dclink_limit_active [*6];
    endsequence
    sequence no_curr_s;
        (i_motor_current == 16'h0000) [*6];
    endsequence
    bus_always_ready_a: assert property (o_hreadyout && !o_hresp)
        else $error("bus slave not ready or not okay");
    sleep_pulse_off_a: assert property (
        o_inverter_state_code == `DSF_STATE_SLEEP |-> !o_drive.pulse_enable)
        else $error("pulses enabled while sleeping");
    dcl_priority_a: assert property (
        dcl_on_s |-> !o_drive.ramp_force_zero)
        else $error("current limit acts during dc-link limiting");
    force_cause_a: assert property (
        no_curr_s |-> !o_drive.ramp_force_zero)
        else $error("ramp forced to zero without current");
    vramp_one_cycle_a: assert property (
        o_drive.vramp_start |=> !o_drive.vramp_start)
        else $error("voltage ramp start longer than one cycle");
    fault_state_a: assert property (
        o_dc_link_undervoltage_fault |->
            o_inverter_state_code == `DSF_STATE_FAULT &&
            !o_drive.pulse_enable)
        else $error("fault without fault code or with pulses");
    idle_quiet_a: assert property (
        run_low_s |-> !o_drive.dc_brake && !o_drive.pulse_enable)
        else $error("braking or pulses without run command");
    reset_clear_a: assert property (disable iff (1'b0)
        i_rst |=> o_drive == '0 && o_inverter_state_code == 4'h0)
        else $error("outputs not cleared by reset");
endmodule // dsf_supervisor_chk

bind dsf_supervisor dsf_supervisor_chk u_dsf_supervisor_chk (
    .i_clk_sys, .i_rst, .i_run_cmd, .i_dclink_limit_active,
    .i_motor_current, .o_hreadyout, .o_hresp, .o_drive,
    .o_inverter_state_code, .o_dc_link_undervoltage_fault);
